// ==== sdc_ctrl.sv ====
`timescale 1ns/1ps
module sdc_ctrl #(
  parameter int POWER_WAIT_CYC = sdc_pkg::TPOWER_CYC
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             req_valid,
  input  wire sdc_pkg::sdc_req_t req,
  input  wire logic             sr_req,
  output logic                  req_ready,
  output logic                  rd_valid,
  output logic [31:0]           rd_data,
  output logic                  init_done,
  output logic                  sdram_clk,
  output logic                  sdram_cke,
  output sdc_pkg::sdc_cmd_t     sdram_cmd,
  output logic [1:0]            sdram_ba,
  output logic [10:0]           sdram_addr,
  output logic [3:0]            sdram_dqm,
  input  wire logic [31:0]      sdram_dq_in,
  output logic [31:0]           sdram_dq_out,
  output logic                  sdram_dq_oe
);

  sdc_pkg::sdc_state_t state;
  sdc_pkg::sdc_req_t   hold;
  logic [15:0]         wait_cnt;
  logic [15:0]         ref_cnt;
  logic                ref_pending;
  logic [1:0]          init_refs;
  logic [3:0]          rrd_cnt;
  logic [3:0]          bank_trc [4];
  logic [15:0]         since_act;
  logic [3:0]          rd_cnt;
  logic [31:0]         dq_s1;
  logic [31:0]         dq_s2;
  logic                go;
  logic                act_issue;
  logic                rdwr_issue;
  logic                pre_issue;
  logic                ref_issue;
  logic                mrs_issue;
  logic                sr_exit;

  // Command slots fall on the edge where the divided clock drops
  assign go         = sdram_clk && (wait_cnt == 16'h0000);
  assign act_issue  = go && (state == sdc_pkg::S_ACT) && (bank_trc[hold.bank] == 4'h0) && (rrd_cnt == 4'h0);
  assign rdwr_issue = go && (state == sdc_pkg::S_RDWR);
  assign pre_issue  = go && (state == sdc_pkg::S_PRE) && (since_act >= 16'(sdc_pkg::TRAS_MIN_CYC - 1));
  assign ref_issue  = go && (state == sdc_pkg::S_REF);
  assign mrs_issue  = go && (state == sdc_pkg::S_MRS);
  assign sr_exit    = go && (state == sdc_pkg::S_SR_HOLD) && !sr_req;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // The controller owns the memory clock; no second domain on this side
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sdram_clk <= 1'b0;
    else
      sdram_clk <= ~sdram_clk;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_s1 <= 32'h0000_0000;
      dq_s2 <= 32'h0000_0000;
    end
    else
    begin
      dq_s1 <= sdram_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // R7: refresh timer; a new due event beats the clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_cnt     <= 16'(sdc_pkg::TREFI_CYC - 1);
      ref_pending <= 1'b0;
    end
    else
    begin
      ref_cnt     <= (ref_cnt == 16'h0000) ? 16'(sdc_pkg::TREFI_CYC - 1) : ref_cnt - 16'h0001;
      ref_pending <= (ref_cnt == 16'h0000) || (ref_pending && !ref_issue);
    end
  end

  // R18: per-bank row-cycle counters and bank-to-bank gap, in whole cycles
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rrd_cnt   <= 4'h0;
      since_act <= 16'hFFFF;
      for (int i = 0; i < 4; i++)
        bank_trc[i] <= 4'h0;
    end
    else
    begin
      // R4: any-bank activate spacing
      rrd_cnt   <= act_issue ? 4'(sdc_pkg::BANK_TO_BANK_ACTIVATE_GAP_CYC - 1) : (rrd_cnt != 4'h0) ? rrd_cnt - 4'h1 : rrd_cnt;
      since_act <= act_issue ? 16'h0000 : sat_inc(since_act);
      for (int i = 0; i < 4; i++)
      begin
        // R1: same-bank activate spacing
        if (act_issue && (hold.bank == 2'(i)))
          bank_trc[i] <= 4'(sdc_pkg::TRC_CYC - 1);
        else if (bank_trc[i] != 4'h0)
          bank_trc[i] <= bank_trc[i] - 4'h1;
      end
    end
  end

  // Read capture after CAS latency plus the two synchroniser stages
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_cnt   <= 4'h0;
      rd_valid <= 1'b0;
      rd_data  <= 32'h0000_0000;
    end
    else
    begin
      rd_valid <= (rd_cnt == 4'h1);
      if (rd_cnt == 4'h1)
        rd_data <= dq_s2;
      if (rdwr_issue && !hold.write)
        rd_cnt <= 4'(sdc_pkg::RD_CAPTURE_CYC);
      else if (rd_cnt != 4'h0)
        rd_cnt <= rd_cnt - 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= sdc_pkg::S_POWER;
      hold         <= '0;
      wait_cnt     <= 16'(POWER_WAIT_CYC - 1);
      init_refs    <= 2'h0;
      init_done    <= 1'b0;
      req_ready    <= 1'b0;
      sdram_cke    <= 1'b0;
      sdram_cmd    <= sdc_pkg::CMD_NOP;
      sdram_ba     <= 2'h0;
      sdram_addr   <= 11'h000;
      sdram_dqm    <= 4'hF;
      sdram_dq_out <= 32'h0000_0000;
      sdram_dq_oe  <= 1'b0;
    end
    else
    begin
      if (wait_cnt != 16'h0000)
        wait_cnt <= wait_cnt - 16'h0001;
      if (sdram_clk)
      begin
        sdram_cmd   <= sdc_pkg::CMD_NOP;
        sdram_dq_oe <= 1'b0;
      end
      case (state)
        // R10 R11: clock enable low, mask high, NOP until the wait ends
        sdc_pkg::S_POWER:
          if (go)
          begin
            sdram_cke <= 1'b1;
            state     <= sdc_pkg::S_PREALL;
          end
        // R12: precharge all banks first
        sdc_pkg::S_PREALL:
          if (go)
          begin
            sdram_cmd  <= sdc_pkg::CMD_PRE;
            sdram_addr <= 11'(1 << sdc_pkg::PREALL_BIT);
            wait_cnt   <= 16'(sdc_pkg::TRP_CYC - 1);
            state      <= sdc_pkg::S_INIT_REF;
          end
        // R14 R15: dummy refreshes placed before the mode set
        sdc_pkg::S_INIT_REF:
          if (go)
          begin
            sdram_cmd <= sdc_pkg::CMD_REF;
            wait_cnt  <= 16'(sdc_pkg::TRFC_CYC - 1);
            init_refs <= init_refs + 2'h1;
            if (init_refs == 2'(sdc_pkg::INIT_REFS - 1))
              state <= sdc_pkg::S_MRS;
          end
        // R13 R9: program mode, then hold off for the set cycle time
        sdc_pkg::S_MRS:
          if (go)
          begin
            sdram_cmd  <= sdc_pkg::CMD_MRS;
            sdram_ba   <= 2'h0;
            sdram_addr <= sdc_pkg::MODE_WORD;
            sdram_dqm  <= 4'h0;
            wait_cnt   <= 16'(sdc_pkg::TMRD_CYC - 1);
            init_done  <= 1'b1;
            req_ready  <= 1'b1;
            state      <= sdc_pkg::S_IDLE;
          end
        sdc_pkg::S_IDLE:
          if (req_valid && req_ready)
          begin
            hold      <= req;
            req_ready <= 1'b0;
            state     <= sdc_pkg::S_ACT;
          end
          else if (ref_pending)
          begin
            req_ready <= 1'b0;
            state     <= sdc_pkg::S_REF;
          end
          else if (sr_req)
          begin
            req_ready <= 1'b0;
            state     <= sdc_pkg::S_SR_ENTER;
          end
        // R3: wait_cnt still holds the precharge recovery here
        sdc_pkg::S_ACT:
          if (act_issue)
          begin
            sdram_cmd  <= sdc_pkg::CMD_ACT;
            sdram_ba   <= hold.bank;
            sdram_addr <= hold.row;
            wait_cnt   <= 16'(sdc_pkg::TRCD_CYC - 1);
            state      <= sdc_pkg::S_RDWR;
          end
        // R2 R6: column command once the RAS-CAS delay has run
        sdc_pkg::S_RDWR:
          if (go)
          begin
            sdram_cmd  <= hold.write ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD;
            sdram_addr <= {3'h0, hold.col};
            if (hold.write)
            begin
              sdram_dq_out <= hold.wdata;
              sdram_dq_oe  <= 1'b1;
            end
            // Reads wait for capture so a later read cannot reload the pipe
            wait_cnt <= hold.write ? 16'(sdc_pkg::TWR_CYC - 1) : 16'(sdc_pkg::RD_CAPTURE_CYC);
            state    <= sdc_pkg::S_PRE;
          end
        // R5: close the row only after the minimum active time
        sdc_pkg::S_PRE:
          if (pre_issue)
          begin
            sdram_cmd  <= sdc_pkg::CMD_PRE;
            sdram_addr <= 11'h000;
            wait_cnt   <= 16'(sdc_pkg::TRP_CYC - 1);
            req_ready  <= 1'b1;
            state      <= sdc_pkg::S_IDLE;
          end
        // R16: closed-page policy keeps every bank idle here
        sdc_pkg::S_REF:
          if (go)
          begin
            sdram_cmd <= sdc_pkg::CMD_REF;
            wait_cnt  <= 16'(sdc_pkg::TRFC_CYC - 1);
            req_ready <= 1'b1;
            state     <= sdc_pkg::S_IDLE;
          end
        sdc_pkg::S_SR_ENTER:
          if (go)
          begin
            sdram_cmd <= sdc_pkg::CMD_REF;
            sdram_cke <= 1'b0;
            wait_cnt  <= 16'(sdc_pkg::TRAS_MIN_CYC - 1);
            state     <= sdc_pkg::S_SR_HOLD;
          end
        // R8 R17: after exit only NOPs until the exit time has passed
        sdc_pkg::S_SR_HOLD:
          if (sr_exit)
          begin
            sdram_cke <= 1'b1;
            wait_cnt  <= 16'(sdc_pkg::TXSR_CYC - 1);
            req_ready <= 1'b1;
            state     <= sdc_pkg::S_IDLE;
          end
        default:
          state <= sdc_pkg::S_POWER;
      endcase
    end
  end

  // Helper ages, counted from each command's issue edge (age_rst and age_ref from reset, age_ref held at zero in self-refresh), for checking only
  logic [15:0] age_pre;
  logic [15:0] age_ref;
  logic [15:0] age_mrs;
  logic [15:0] age_xsr;
  logic [15:0] age_rst;
  logic [15:0] bank_age [4];
  logic        prea_seen;
  logic        any_issue;

  assign any_issue = act_issue || rdwr_issue || pre_issue || ref_issue || mrs_issue;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age_pre   <= 16'hFFFF;
      age_ref   <= 16'h0000;
      age_mrs   <= 16'hFFFF;
      age_xsr   <= 16'hFFFF;
      age_rst   <= 16'h0000;
      prea_seen <= 1'b0;
      for (int i = 0; i < 4; i++)
        bank_age[i] <= 16'hFFFF;
    end
    else
    begin
      age_pre   <= (pre_issue || (go && state == sdc_pkg::S_PREALL)) ? 16'h0000 : sat_inc(age_pre);
      age_ref   <= (ref_issue || state == sdc_pkg::S_SR_HOLD) ? 16'h0000 : sat_inc(age_ref);
      age_mrs   <= mrs_issue ? 16'h0000 : sat_inc(age_mrs);
      age_xsr   <= sr_exit ? 16'h0000 : sat_inc(age_xsr);
      age_rst   <= sat_inc(age_rst);
      prea_seen <= prea_seen || (go && state == sdc_pkg::S_PREALL);
      for (int i = 0; i < 4; i++)
        bank_age[i] <= (act_issue && hold.bank == 2'(i)) ? 16'h0000 : sat_inc(bank_age[i]);
    end
  end

  chk_act_same_bank: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    act_issue |-> bank_age[hold.bank] >= 16'(sdc_pkg::TRC_CYC - 1))
    else $error("same-bank activate too soon");

  chk_act_to_col: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    rdwr_issue |-> since_act >= 16'(sdc_pkg::TRCD_CYC - 1) && $past(since_act) != 16'hFFFF)
    else $error("column command too soon after activate");

  chk_pre_recovery: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    (act_issue || ref_issue) |-> age_pre >= 16'(sdc_pkg::TRP_CYC - 1))
    else $error("activate or refresh too soon after precharge");

  chk_act_any_bank: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
    act_issue |-> since_act >= 16'(sdc_pkg::BANK_TO_BANK_ACTIVATE_GAP_CYC - 1))
    else $error("activates to different banks too close");

  chk_active_window: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    pre_issue |-> since_act >= 16'(sdc_pkg::TRAS_MIN_CYC - 1) && since_act <= 16'(sdc_pkg::TRAS_MAX_CYC))
    else $error("row active time out of range");

  chk_col_slot: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    rdwr_issue |=> !sdram_clk && sdram_cmd == (hold.write ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD)
    ##1 sdram_cmd == (hold.write ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD))
    else $error("column command not driven for its slot");

  chk_refresh_interval: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    init_done |-> age_ref < 16'(2 * sdc_pkg::TREFI_CYC))
    else $error("refresh interval exceeded");

  chk_sr_exit_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
    age_xsr < 16'(sdc_pkg::TXSR_CYC - 1) |-> !any_issue)
    else $error("command issued during self-refresh exit");

  chk_mrs_gap: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    any_issue |-> age_mrs >= 16'(sdc_pkg::TMRD_CYC - 1))
    else $error("command too soon after mode set");

  chk_power_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    !prea_seen && !sdram_cke |-> sdram_dqm == 4'hF && sdram_cmd == sdc_pkg::CMD_NOP)
    else $error("pins not quiet during power-up");

  chk_power_wait: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
    $rose(sdram_cke) && !init_done && !prea_seen |-> age_rst >= 16'(POWER_WAIT_CYC))
    else $error("clock enable raised before stabilisation time");

  chk_init_order: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
    (ref_issue || mrs_issue) |-> prea_seen)
    else $error("init command before precharge all");

  chk_init_done: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    $rose(init_done) |-> init_refs == 2'(sdc_pkg::INIT_REFS) && age_mrs == 16'h0000)
    else $error("init finished without refreshes and mode set");

  chk_access_after_init: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
    act_issue |-> init_done)
    else $error("access before mode register set");

  chk_refresh_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
    ref_issue |-> sdram_cke && since_act > 16'(sdc_pkg::TRAS_MIN_CYC) && age_pre >= 16'(sdc_pkg::TRP_CYC - 1))
    else $error("refresh with a bank possibly open");

  chk_nop_after_ref: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
    any_issue && init_done |-> age_ref >= 16'(sdc_pkg::TRFC_CYC - 1))
    else $error("command during refresh cycle");

endmodule

// ==== sdc_mem_model.sv ====
`timescale 1ns/1ps
module sdc_mem_model #(
  parameter int STABLE_NS = 800,
  parameter int TCK_NS    = 80
) (
  input  wire logic              sdram_clk,
  input  wire logic              sdram_cke,
  input  wire sdc_pkg::sdc_cmd_t sdram_cmd,
  input  wire logic [1:0]        sdram_ba,
  input  wire logic [10:0]       sdram_addr,
  input  wire logic [3:0]        sdram_dqm,
  input  wire logic [31:0]       sdram_dq_out,
  input  wire logic              sdram_dq_oe,
  output logic [31:0]            sdram_dq_in,
  output int                     viol_count,
  output int                     ref_count
);
  logic [31:0] mem [logic [20:0]];
  logic [10:0] open_row [4];
  logic [20:0] key, rd_key [2];
  logic [3:0]  open_b = 4'h0;
  logic [1:0]  rd_pipe = 2'h0;
  logic        up = 1'b0, cold = 1'b0, mrs_done, in_sr = 1'b0, pre_seen;
  realtime     t_act [4] = '{4{-1.0e6}};
  realtime     t_pre [4] = '{4{-1.0e6}};
  realtime     now, t_up, t_sr, t_act_any = -1.0e6, t_pre_any = -1.0e6;
  realtime     t_ref = -1.0e6, t_mrs = -1.0e6, t_exit = -1.0e6;
  int          init_refs;

  task automatic flag(input int code);
    viol_count++;
    $display("sdram model: illegal command, code %0d at %0t", code, $time);
  endtask

  initial
  begin
    viol_count = 0;
    ref_count = 0;
    sdram_dq_in = 32'h0000_0000;
  end

  always @(posedge sdram_clk)
  begin
    now = $realtime;
    // Released bus toggles so a late sample never matches by luck
    sdram_dq_in <= !rd_pipe[1] ? ~sdram_dq_in :
                   mem.exists(rd_key[1]) ? mem[rd_key[1]] : {11'h000, rd_key[1]} ^ 32'hA5A5_A5A5;
    rd_pipe = {rd_pipe[0], 1'b0};
    rd_key[1] = rd_key[0];
    if (up && !in_sr && !sdram_cke && sdram_cmd === sdc_pkg::CMD_REF)
    begin
      if (open_b != 4'h0)
        flag(16);
      in_sr = 1'b1;
      t_sr = now;
    end
    else if (in_sr && sdram_cke)
    begin
      if (now - t_sr < sdc_pkg::TRAS_MIN_NS)
        flag(5);
      in_sr = 1'b0;
      t_exit = now;
    end
    else if (!in_sr && !sdram_cke)
    begin
      if (!cold)
      begin
        cold = 1'b1;
        up = 1'b0;
        mrs_done = 1'b0;
        pre_seen = 1'b0;
        init_refs = 0;
        t_up = now;
      end
      if (sdram_cmd !== sdc_pkg::CMD_NOP || sdram_dqm !== 4'hF)
        flag(10);
    end
    else if (cold)
    begin
      // stable clock before enable, one clock of slack for the register
      if (now - t_up < STABLE_NS - TCK_NS)
        flag(11);
      cold = 1'b0;
      up = 1'b1;
    end
    if (up && !in_sr && sdram_cmd !== sdc_pkg::CMD_NOP)
    begin
      if (!pre_seen && !(sdram_cmd === sdc_pkg::CMD_PRE && sdram_addr[10]))
        flag(12);
      if (now - t_mrs < 2 * TCK_NS)
        flag(9);
      if (now - t_ref < sdc_pkg::TRFC_NS || now - t_exit < sdc_pkg::TRC_NS + sdc_pkg::TIS_PS / 1000.0)
        flag(8);
      key = {sdram_ba, open_row[sdram_ba], sdram_addr[7:0]};
      case (sdram_cmd)
        sdc_pkg::CMD_ACT:
        begin
          if (!mrs_done || init_refs < sdc_pkg::INIT_REFS)
            flag(13);
          if (open_b[sdram_ba] || now - t_act[sdram_ba] < sdc_pkg::TRC_NS ||
              now - t_pre[sdram_ba] < sdc_pkg::TRP_NS || now - t_act_any < sdc_pkg::BANK_TO_BANK_ACTIVATE_GAP_NS)
            flag(1);
          open_b[sdram_ba] = 1'b1;
          open_row[sdram_ba] = sdram_addr;
          t_act[sdram_ba] = now;
          t_act_any = now;
        end
        sdc_pkg::CMD_RD, sdc_pkg::CMD_WR:
        begin
          if (!open_b[sdram_ba] || now - t_act[sdram_ba] < sdc_pkg::TRCD_NS)
            flag(2);
          if (sdram_cmd === sdc_pkg::CMD_RD)
          begin
            rd_pipe[0] = 1'b1;
            rd_key[0] = key;
          end
          else if (sdram_dq_oe === 1'b1 && sdram_dqm === 4'h0)
            mem[key] = sdram_dq_out;
          else
            flag(4);
        end
        sdc_pkg::CMD_PRE:
        begin
          for (int b = 0; b < 4; b++)
            if (sdram_addr[10] || sdram_ba == b)
            begin
              if (open_b[b] && (now - t_act[b] < sdc_pkg::TRAS_MIN_NS || now - t_act[b] > sdc_pkg::TRAS_MAX_NS))
                flag(5);
              open_b[b] = 1'b0;
              t_pre[b] = now;
            end
          t_pre_any = now;
          pre_seen = 1'b1;
        end
        sdc_pkg::CMD_REF:
        begin
          if (open_b != 4'h0 || now - t_pre_any < sdc_pkg::TRP_NS)
            flag(16);
          ref_count++;
          init_refs++;
          t_ref = now;
        end
        sdc_pkg::CMD_MRS:
        begin
          mrs_done = 1'b1;
          t_mrs = now;
        end
        default:
          flag(0);
      endcase
    end
  end
endmodule

// ==== sdc_pkg.sv ====
// Contract
// R1: Same-bank activates spaced by row cycle.
// R2: Activate to read/write waits RAS-CAS delay.
// R3: Precharge to refresh/activate waits recovery.
// R4: Activates to different banks spaced apart.
// R5: Bank active between minimum and maximum time.
// R6: Column commands may follow one cycle apart.
// R7: Average auto-refresh interval at most 15.6us. Code serves a waiting request before a due refresh and holds only one pending.
// R8: After self-refresh exit wait row cycle+setup.
// R9: Mode register set then two clocks.
// R10: Power-on: clock enable low, mask high, NOP.
// R11: Stable clock 200us before clock enable.
// R12: Precharge all banks after stabilisation.
// R13: Program mode register before normal accesses.
// R14: At least two initial auto-refreshes.
// R15: Initial refreshes before or after mode set.
// R16: Refresh only with all banks idle.
// R17: Only NOP until self-refresh exit completes.
// R18: Round minimums up, count per bank.
package sdc_pkg;

  localparam int CLK_PERIOD_PS = 40000;
  localparam int CLK_DIV       = 2;
  localparam bit FAST_GRADE    = 1'b0;

  function automatic int ceil_cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int floor_cyc(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int TRC_NS       = FAST_GRADE ? 55 : 60;
  localparam int TRCD_NS      = FAST_GRADE ? 15 : 18;
  localparam int TRP_NS       = FAST_GRADE ? 15 : 18;
  localparam int BANK_TO_BANK_ACTIVATE_GAP_NS      = FAST_GRADE ? 10 : 12;
  localparam int TRAS_MIN_NS  = FAST_GRADE ? 40 : 42;
  localparam int TRAS_MAX_NS  = 100000;
  localparam int TRFC_NS      = FAST_GRADE ? 55 : 60;
  localparam int TIS_PS       = 1500;
  localparam int TREFI_NS     = 15600;
  localparam int TPOWER_US    = 200;
  localparam int TWR_TCK      = 2;
  localparam int TMRD_TCK     = 2;
  localparam int INIT_REFS    = 2;
  localparam int CAS_LAT      = 2;

  localparam int TRC_CYC      = ceil_cyc(TRC_NS * 1000);
  localparam int TRCD_CYC     = ceil_cyc(TRCD_NS * 1000);
  localparam int TRP_CYC      = ceil_cyc(TRP_NS * 1000);
  localparam int BANK_TO_BANK_ACTIVATE_GAP_CYC     = ceil_cyc(BANK_TO_BANK_ACTIVATE_GAP_NS * 1000);
  localparam int TRAS_MIN_CYC = ceil_cyc(TRAS_MIN_NS * 1000);
  localparam int TRAS_MAX_CYC = floor_cyc(TRAS_MAX_NS * 1000);
  localparam int TRFC_CYC     = ceil_cyc(TRFC_NS * 1000);
  localparam int TXSR_CYC     = ceil_cyc(TRC_NS * 1000 + TIS_PS);
  localparam int TREFI_CYC    = floor_cyc(TREFI_NS * 1000);
  localparam int TPOWER_CYC   = ceil_cyc(TPOWER_US * 1000000);
  localparam int TWR_CYC      = TWR_TCK * CLK_DIV;
  localparam int TMRD_CYC     = TMRD_TCK * CLK_DIV;
  localparam int RD_CAPTURE_CYC = CLK_DIV * (CAS_LAT + 1) + 2;

  localparam int PREALL_BIT   = 10;
  localparam int MODE_CL_POS  = 4;
  localparam logic [10:0] MODE_WORD = 11'h020;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdc_cmd_t;

  localparam sdc_cmd_t CMD_NOP = 4'h7;
  localparam sdc_cmd_t CMD_ACT = 4'h3;
  localparam sdc_cmd_t CMD_RD  = 4'h5;
  localparam sdc_cmd_t CMD_WR  = 4'h4;
  localparam sdc_cmd_t CMD_PRE = 4'h2;
  localparam sdc_cmd_t CMD_REF = 4'h1;
  localparam sdc_cmd_t CMD_MRS = 4'h0;

  typedef struct packed {
    logic        write;
    logic [1:0]  bank;
    logic [10:0] row;
    logic [7:0]  col;
    logic [31:0] wdata;
  } sdc_req_t;

  typedef enum logic [3:0] {
    S_POWER, S_PREALL, S_INIT_REF, S_MRS, S_IDLE, S_ACT,
    S_RDWR, S_PRE, S_REF, S_SR_ENTER, S_SR_HOLD
  } sdc_state_t;

endpackage

// ==== sdram_cmd_timing_init_bench.sv ====
`timescale 1ns/1ps
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module sdram_cmd_timing_init_bench;
  localparam int PWR_CYC = 20;
  typedef struct packed {sdc_pkg::sdc_req_t r; logic [31:0] exp;} sdc_row_t;
  logic              ref_clk, rst_n, req_valid, sr_req, req_ready, rd_valid, init_done;
  logic              sdram_clk, sdram_cke, sdram_dq_oe;
  sdc_pkg::sdc_req_t req;
  sdc_pkg::sdc_cmd_t sdram_cmd;
  logic [1:0]        sdram_ba;
  logic [10:0]       sdram_addr;
  logic [3:0]        sdram_dqm;
  logic [31:0]       rd_data, sdram_dq_in, sdram_dq_out;
  int                fail_count, tests_run, viol_count, ref_count, base;
  sdc_row_t          rows [$];

  sdc_ctrl #(.POWER_WAIT_CYC(PWR_CYC)) i_sdc_ctrl (.ref_clk, .rst_n, .req_valid, .req, .sr_req,
    .req_ready, .rd_valid, .rd_data, .init_done, .sdram_clk, .sdram_cke, .sdram_cmd, .sdram_ba,
    .sdram_addr, .sdram_dqm, .sdram_dq_in, .sdram_dq_out, .sdram_dq_oe);

  sdc_mem_model #(.STABLE_NS(PWR_CYC * 40)) i_sdc_mem_model (.sdram_clk, .sdram_cke, .sdram_cmd,
    .sdram_ba, .sdram_addr, .sdram_dqm, .sdram_dq_out, .sdram_dq_oe, .sdram_dq_in, .viol_count,
    .ref_count);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return rd_valid === 1'b1;
      1: return init_done === 1'b1;
      default: return sdram_cke === 1'b0;
    endcase
  endfunction

  // Polls on falling edges; a bound that runs out ends the run
  task automatic wait_until(input int s, input int lim);
    int n;
    n = 0;
    while (!pick(s) && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= lim)
    begin
      `CHECK(s, -1)
      close_out();
    end
  endtask

  task automatic send(input sdc_pkg::sdc_req_t r, input logic hold);
    logic taken;
    int   n;
    req = r;
    req_valid = 1'b1;
    taken = 1'b0;
    n = 0;
    while (!taken && n < 3000)
    begin
      @(posedge ref_clk);
      taken = req_ready;
      n++;
    end
    if (!taken)
      wait_until(3, 0);
    @(negedge ref_clk);
    if (!hold)
      req_valid = 1'b0;
  endtask

  task automatic read_back(input int k);
    send(rows[k].r, 1'b0);
    wait_until(0, 200);
    `CHECK(rd_data, rows[k].exp)
  endtask

  task automatic add(input logic w, input logic [1:0] b, input logic [10:0] r, input logic [7:0] c,
                     input logic [31:0] d);
    rows.push_back('{'{w, b, r, c, d}, d});
  endtask

  task automatic rst_chk();
    `CHECK({sdram_clk, sdram_cke, sdram_cmd, sdram_dqm, sdram_dq_oe, req_ready, init_done}, 13'h03F8)
  endtask

  task automatic bring_up();
    wait_until(1, 400);
    `CHECK(sdram_dqm, 4'h0)
    `CHECK(ref_count - base >= sdc_pkg::INIT_REFS, 1'b1)
    `CHECK(viol_count, 0)
  endtask

  initial
  begin
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    sr_req = 1'b0;
    base = 0;
    add(1'b1, 2'h0, 11'h000, 8'h00, 32'h1111_0000);
    add(1'b1, 2'h1, 11'h7FF, 8'hFF, 32'h2222_FFFF);
    add(1'b1, 2'h2, 11'h123, 8'h45, 32'hDEAD_BEEF);
    add(1'b1, 2'h3, 11'h400, 8'h80, 32'h0BAD_F00D);
    add(1'b0, 2'h0, 11'h000, 8'h00, 32'h1111_0000);
    add(1'b0, 2'h1, 11'h7FF, 8'hFF, 32'h2222_FFFF);
    add(1'b0, 2'h2, 11'h123, 8'h45, 32'hDEAD_BEEF);
    add(1'b0, 2'h3, 11'h400, 8'h80, 32'h0BAD_F00D);
    add(1'b1, 2'h2, 11'h123, 8'h45, 32'h1234_5678);
    add(1'b0, 2'h2, 11'h123, 8'h45, 32'h1234_5678);
    add(1'b0, 2'h1, 11'h7FF, 8'hFE, {11'h000, 2'h1, 11'h7FF, 8'hFE} ^ 32'hA5A5_A5A5);
    repeat (3) @(negedge ref_clk);
    rst_chk();
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    bring_up();
    // Writes are held back to back; reads wait for their word
    foreach (rows[i])
      if (rows[i].r.write)
        send(rows[i].r, 1'b1);
      else
        read_back(i);
    `CHECK(viol_count, 0)
    // Self-refresh with a request parked meanwhile
    sr_req = 1'b1;
    wait_until(2, 100);
    repeat (4) @(negedge ref_clk);
    req = rows[4].r;
    req_valid = 1'b1;
    repeat (4) @(negedge ref_clk);
    `CHECK({sdram_cke, req_ready}, 2'b00)
    sr_req = 1'b0;
    read_back(4);
    `CHECK(viol_count, 0)
    base = ref_count;
    repeat (2000) @(negedge ref_clk);
    `CHECK(ref_count - base >= 2000 * 40 / sdc_pkg::TREFI_NS, 1'b1)
    // Reset lands in the middle of an access
    send(rows[3].r, 1'b0);
    rst_n = 1'b0;
    @(negedge ref_clk);
    rst_chk();
    base = ref_count;
    rst_n = 1'b1;
    bring_up();
    read_back(5);
    `CHECK(viol_count, 0)
    close_out();
  end
endmodule
